// ### rtl/lfp_core.sv
// core: detection, power save, thermal and reference fault control with staggered outputs
//
// Operation
// [RQ1] detection enable starts detection current on all outputs at first grayscale clock
// [RQ2] detection current stops at timing-field count; open and short flags captured then
// [RQ3] grayscale pwm keeps running beside the detection current
// [RQ4] detection disabled: outputs follow only their grayscale value
// [RQ5] controller keeps outputs on at least 1 us before capture
// [RQ6] controller picks smallest timing setting above 1 us over clock period
// [RQ7] no detection current and no capture while in power save
// [RQ8] fault flags read 1 for fault: open low, short high, leakage when off
// [RQ9] power save armed when low two field bits nonzero
// [RQ10] field 01 or 10 and all-zero second grayscale write enters power save
// [RQ11] shift clock rising edge with field 01 leaves power save
// [RQ12] after leaving power save outputs stay off until next period start
// [RQ13] shorted reference pin sets its flag and forces all outputs off
// [RQ14] warning flag follows warning comparator, never forces outputs off
// [RQ15] warning flag clears at grayscale latch pulse if comparator is low
// [RQ16] shutdown comparator forces outputs off and sets error flag at once
// [RQ17] error flag clears only at grayscale latch pulse after comparator deasserts; code clears it at any latch pulse
// [RQ18] after shutdown outputs return at next period start with blank low; code also waits for the error flag to clear
// [RQ19] shutdown latch released by grayscale latch pulse with timing reset enabled
// [RQ20] outputs switch in four delayed groups, edges still tied to grayscale clock
// [RQ21] leakage flags frozen while detection mode enabled
// [RQ22] detection off: open and short flags of off outputs read 0
`timescale 1ns/1ns
module lfp_core #(
    parameter int CHANNELS = lfp_pkg::CHANNELS,
    parameter int GS_BITS = lfp_pkg::GS_BITS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic grayscale_clock,
    input wire logic shift_clock,
    input wire logic latch_pulse,
    input wire logic latch_is_gs_write,
    input wire logic second_gs_all_zero,
    input wire logic timing_reset_enable,
    input wire logic blank,
    input wire logic invisible_detect_enable,
    input wire logic [1:0] detect_current_select,
    input wire logic [1:0] fault_latch_timing,
    input wire logic [1:0] power_save_field,
    input wire logic leakage_detect_enable,
    input wire logic [CHANNELS*GS_BITS-1:0] grayscale_value,
    input wire logic [CHANNELS-1:0] open_compare,
    input wire logic [CHANNELS-1:0] short_compare,
    input wire logic reference_short_compare,
    input wire logic warning_compare,
    input wire logic shutdown_compare,
    output logic [CHANNELS-1:0] sink_output_channel,
    output logic [CHANNELS-1:0] detect_sink_on,
    output logic [1:0] detect_current_level,
    output logic [CHANNELS-1:0] open_fault_flag,
    output logic [CHANNELS-1:0] short_fault_flag,
    output logic [CHANNELS-1:0] leakage_fault_flag,
    output logic reference_short_flag,
    output logic thermal_warning_flag,
    output logic thermal_error_flag,
    output logic power_save_state
);
    import lfp_pkg::*;

    // ==========================================================
    // reset release and input synchronisers
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [2:0] edge_hist;
    wire [NSYNC-1:0] raw_in = {shift_clock, grayscale_clock, latch_pulse, blank,
        reference_short_compare, warning_compare, shutdown_compare, 1'b0};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
            edge_hist <= 3'h0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            edge_hist <= sync_b[7:5];
        end
    end
    wire sclk_rise = sync_b[7] && !edge_hist[2];
    wire gclk_rise = sync_b[6] && !edge_hist[1];
    wire lat_rise = sync_b[5] && !edge_hist[0];
    wire blank_s = sync_b[4];
    wire current_reference_pin_short = sync_b[3];
    wire warn_s = sync_b[2];
    wire tsd_s = sync_b[1];
    wire gs_lat = lat_rise && latch_is_gs_write;

    // ==========================================================
    // display period counter
    logic [GS_BITS-1:0] gs_count;
    logic period_start;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) gs_count <= '0;
        else if (gs_lat && timing_reset_enable) gs_count <= '0;
        else if (gclk_rise) gs_count <= gs_count + 1'b1;
    end
    // count is zero at the first grayscale clock of each period
    wire first_gclk = gclk_rise && (gs_count == '0);

    // ==========================================================
    // power save state machine
    lfp_state_t state;
    lfp_state_t next_state;
    wire ps_armed = (power_save_field != PS_OFF); // RQ9
    wire ps_enter = ps_armed && (power_save_field != 2'h3) && gs_lat
        && second_gs_all_zero; // RQ10
    always_comb begin
        next_state = state;
        case (state)
            LFP_RUN: if (ps_enter) next_state = LFP_SAVE;
            LFP_SAVE: if (sclk_rise && power_save_field == PS_WAKE) next_state = LFP_WAIT; // RQ11
            LFP_WAIT: if (first_gclk) next_state = LFP_RUN; // RQ12
            default: next_state = LFP_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) state <= LFP_RUN;
        else state <= next_state;
    end
    wire run = (state == LFP_RUN);

    // ==========================================================
    // thermal and reference faults
    logic shut_latched;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_latched <= 1'b0;
            thermal_error_flag <= 1'b0;
            thermal_warning_flag <= 1'b0;
            reference_short_flag <= 1'b0;
        end else begin
            reference_short_flag <= current_reference_pin_short; // RQ13
            if (warn_s) thermal_warning_flag <= 1'b1; // RQ14
            else if (gs_lat) thermal_warning_flag <= 1'b0; // RQ15
            if (tsd_s) thermal_error_flag <= 1'b1; // RQ16
            else if (lat_rise) thermal_error_flag <= 1'b0; // RQ17
            if (tsd_s) shut_latched <= 1'b1; // RQ16
            else if (gs_lat && timing_reset_enable) shut_latched <= 1'b0; // RQ19
            else if (first_gclk && !blank_s && !thermal_error_flag) shut_latched <= 1'b0; // RQ18
        end
    end
    // comparator forces off at once, latch holds it after the comparator drops
    wire force_off = tsd_s || shut_latched || current_reference_pin_short || !run || blank_s; // RQ13 RQ16

    // ==========================================================
    // detection window
    logic [GS_BITS-1:0] latch_count;
    always_comb begin
        case (fault_latch_timing)
            2'h0: latch_count = LATCH_COUNT_0;
            2'h1: latch_count = LATCH_COUNT_1;
            2'h2: latch_count = LATCH_COUNT_2;
            default: latch_count = LATCH_COUNT_3;
        endcase
    end
    wire idm_ok = invisible_detect_enable && run; // RQ7
    wire capture = gclk_rise && (gs_count + 1'b1 == latch_count) && run; // RQ2 RQ7
    logic idm_active;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) idm_active <= 1'b0;
        else if (!idm_ok || capture) idm_active <= 1'b0; // RQ2
        else if (first_gclk) idm_active <= 1'b1; // RQ1
    end

    // ==========================================================
    // per-channel pwm, stagger and flags
    logic [3:0] step_cnt;
    logic [GROUPS-1:0] grp_en;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= 4'h0;
            grp_en <= '0;
        end else begin
            // group k is enabled one step after group k-1, each step counted on the system clock
            step_cnt <= (step_cnt == GROUP_STEP_CYCLES) ? 4'h0 : step_cnt + 4'h1;
            if (step_cnt == GROUP_STEP_CYCLES) grp_en <= {grp_en[GROUPS-2:0], 1'b1}; // RQ20
        end
    end
    logic [CHANNELS-1:0] pwm_on;
    logic [CHANNELS-1:0] pwm_stag;
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
            wire [GS_BITS-1:0] gsv = grayscale_value[ch*GS_BITS +: GS_BITS];
            wire [1:0] grp = GROUP_MAP[2*ch +: 2];
            // pwm from grayscale value only; detection never alters it
            assign pwm_on[ch] = (gsv > gs_count); // RQ3 RQ4
            logic [GROUPS-1:0] dly;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) dly <= '0;
                else dly <= {dly[GROUPS-2:0], pwm_on[ch]}; // RQ20
            end
            assign pwm_stag[ch] = dly[grp];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sink_output_channel[ch] <= 1'b0;
                    detect_sink_on[ch] <= 1'b0;
                    open_fault_flag[ch] <= FLAGS_RESET[ch];
                    short_fault_flag[ch] <= FLAGS_RESET[ch];
                    leakage_fault_flag[ch] <= FLAGS_RESET[ch];
                end else begin
                    sink_output_channel[ch] <= pwm_stag[ch] && !force_off && grp_en[grp]; // RQ20
                    detect_sink_on[ch] <= idm_active && !force_off; // RQ1 RQ3
                    if (capture) begin
                        // RQ8 RQ22
                        open_fault_flag[ch] <= (pwm_on[ch] || idm_active) && open_compare[ch];
                        short_fault_flag[ch] <= (pwm_on[ch] || idm_active) && short_compare[ch];
                    end
                    if (first_gclk && !invisible_detect_enable) // RQ21
                        leakage_fault_flag[ch] <= leakage_detect_enable && (gsv == '0)
                            && !short_compare[ch]; // RQ8
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_current_level <= 2'h0;
            power_save_state <= 1'b0;
        end else begin
            detect_current_level <= detect_current_select; // RQ1
            // waiting for the next period counts as awake; outputs stay off via run
            power_save_state <= (state == LFP_SAVE); // RQ11
        end
    end
endmodule : lfp_core

// ### rtl/lfp_pkg.sv
// package: constants and types for the led driver fault and power control block
package lfp_pkg;
    localparam int CHANNELS = 16;
    localparam int GS_BITS = 12;
    localparam int GROUPS = 4;
    // one group step of the enable ramp after reset is this many system clocks plus one
    localparam logic [3:0] GROUP_STEP_CYCLES = 4'h2;
    // grayscale clock counts at which detection current stops, per timing field code
    localparam logic [GS_BITS-1:0] LATCH_COUNT_0 = 12'h002;
    localparam logic [GS_BITS-1:0] LATCH_COUNT_1 = 12'h021;
    localparam logic [GS_BITS-1:0] LATCH_COUNT_2 = 12'h041;
    localparam logic [GS_BITS-1:0] LATCH_COUNT_3 = 12'h081;
    localparam logic [1:0] PS_OFF = 2'h0;
    localparam logic [1:0] PS_WAKE = 2'h1;
    localparam logic [1:0] PS_SLEEP = 2'h2;
    localparam logic [CHANNELS-1:0] FLAGS_RESET = 16'h0000;
    // channel to switching group map, two bits per channel, channel 0 in the low bits
    localparam logic [31:0] GROUP_MAP = 32'h1be4_1be4;
    typedef enum logic [1:0] {
        LFP_RUN = 2'b00,
        LFP_SAVE = 2'b01,
        LFP_WAIT = 2'b10
    } lfp_state_t;
endpackage : lfp_pkg

// ### verification/lfp_core_props.sv
// checker: port assertions for the fault and power control core
`timescale 1ns/1ns
module lfp_core_props #(parameter int CHANNELS = 16) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] power_save_field,
    input wire logic reference_short_compare,
    input wire logic warning_compare,
    input wire logic shutdown_compare,
    input wire logic [CHANNELS-1:0] sink_output_channel,
    input wire logic [CHANNELS-1:0] detect_sink_on,
    input wire logic reference_short_flag,
    input wire logic thermal_warning_flag,
    input wire logic thermal_error_flag,
    input wire logic power_save_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // assertions and cover points
    a_save_no_detect: assert property (power_save_state |-> detect_sink_on == '0)
        else $error("detection current in power save");
    a_save_entry_field: assert property (
        $rose(power_save_state) |-> power_save_field inside {2'h1, 2'h2})
        else $error("power save entered with wrong field");
    a_save_exit_off: assert property ($fell(power_save_state) |-> sink_output_channel == '0)
        else $error("outputs on at power save exit");
    a_ref_flag_set: assert property ($rose(reference_short_compare) |-> ##[1:6] reference_short_flag)
        else $error("reference short flag late");
    a_ref_forces_off: assert property (
        reference_short_flag && $past(reference_short_flag) |-> sink_output_channel == '0)
        else $error("outputs on with reference short");
    a_warn_flag_set: assert property ($rose(warning_compare) |-> ##[1:6] thermal_warning_flag)
        else $error("warning flag late");
    a_warn_clear_cond: assert property ($fell(thermal_warning_flag) |-> !warning_compare)
        else $error("warning flag cleared while hot");
    a_err_flag_set: assert property ($rose(shutdown_compare) |-> ##[1:6] thermal_error_flag)
        else $error("error flag late");
    a_err_forces_off: assert property (
        thermal_error_flag && $past(thermal_error_flag) |-> sink_output_channel == '0)
        else $error("outputs on during thermal error");
    a_err_clear_cond: assert property ($fell(thermal_error_flag) |-> !shutdown_compare)
        else $error("error flag cleared while hot");
    c_save: cover property ($rose(power_save_state));
    c_detect: cover property (detect_sink_on != '0);
    c_error: cover property ($rose(thermal_error_flag));
endmodule : lfp_core_props
bind lfp_core lfp_core_props #(.CHANNELS(CHANNELS)) u_props (.clk, .resetn, .power_save_field,
    .reference_short_compare, .warning_compare, .shutdown_compare, .sink_output_channel,
    .detect_sink_on, .reference_short_flag, .thermal_warning_flag, .thermal_error_flag,
    .power_save_state);

// ### verification/lfp_ctrl_model.sv
// partner: controller model driving grayscale clock, latch and shift clock
`timescale 1ns/1ns
module lfp_ctrl_model (
    input wire logic run,
    input wire logic lat_req,
    input wire logic sclk_req,
    output logic grayscale_clock,
    output logic latch_pulse,
    output logic shift_clock
);
    initial begin
        grayscale_clock = 1'b0;
        latch_pulse = 1'b0;
        shift_clock = 1'b0;
        // 160 ns grayscale clock, stands low outside frames
        #3;
        forever begin
            #80;
            grayscale_clock = run ? ~grayscale_clock : 1'b0;
        end
    end
    always @(posedge lat_req) begin
        latch_pulse = 1'b1;
        #80;
        latch_pulse = 1'b0;
    end
    always @(posedge sclk_req) begin
        shift_clock = 1'b1;
        #80;
        shift_clock = 1'b0;
    end
endmodule : lfp_ctrl_model

// ### verification/tb_lfp_core.sv
// testbench: randomised checks of the fault and power control core
`timescale 1ns/1ns
module tb_lfp_core;
    import lfp_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
    logic clk = 1'b0, resetn = 1'b0, run = 1'b0, lat_req = 1'b0, sclk_req = 1'b0;
    logic grayscale_clock, latch_pulse, shift_clock, seen_detect = 1'b0;
    logic latch_is_gs_write = 1'b1, second_gs_all_zero = 1'b0, timing_reset_enable = 1'b1;
    logic blank = 1'b0, invisible_detect_enable = 1'b0, leakage_detect_enable = 1'b0;
    logic reference_short_compare = 1'b0, warning_compare = 1'b0, shutdown_compare = 1'b0;
    logic [1:0] detect_current_select = 2'h0, fault_latch_timing = 2'h0, power_save_field = 2'h0;
    logic [1:0] detect_current_level;
    logic [CHANNELS*GS_BITS-1:0] grayscale_value = '0;
    logic [CHANNELS-1:0] open_compare = '0, short_compare = '0, on_mask, sink_output_channel;
    logic [CHANNELS-1:0] detect_sink_on, open_fault_flag, short_fault_flag, leakage_fault_flag;
    logic reference_short_flag, thermal_warning_flag, thermal_error_flag, power_save_state;
    int n_mismatch = 0, n_checks = 0, cycles = 0, seed = 32'he4e71a79;
    lfp_ctrl_model u_ctrl (.run, .lat_req, .sclk_req, .grayscale_clock, .latch_pulse,
        .shift_clock);
    lfp_core u_dut (.clk, .resetn, .grayscale_clock, .shift_clock, .latch_pulse,
        .latch_is_gs_write, .second_gs_all_zero, .timing_reset_enable, .blank,
        .invisible_detect_enable, .detect_current_select, .fault_latch_timing,
        .power_save_field, .leakage_detect_enable, .grayscale_value, .open_compare,
        .short_compare, .reference_short_compare, .warning_compare, .shutdown_compare,
        .sink_output_channel, .detect_sink_on, .detect_current_level, .open_fault_flag,
        .short_fault_flag, .leakage_fault_flag, .reference_short_flag,
        .thermal_warning_flag, .thermal_error_flag, .power_save_state);
    // ==========================================
    // clock, watchdog and tasks
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if ((|detect_sink_on) === 1'b1) seen_detect = 1'b1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task pulse_lat;
        lat_req = 1'b1;
        tick(1);
        lat_req = 1'b0;
        tick(20);
    endtask : pulse_lat
    task frame(input int n);
        pulse_lat();
        run = 1'b1;
        tick(16 * n);
        run = 1'b0;
        tick(20);
    endtask : frame
    task print_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================
    // main sequence
    initial begin
        tick(3);
        resetn = 1'b1;
        tick(3);
        fault_latch_timing = 2'h1;
        for (int i = 0; i < 4; i++) begin
            invisible_detect_enable = (i < 2);
            detect_current_select = 2'(i);
            leakage_detect_enable = 1'($random(seed));
            on_mask = (i == 0 || i == 3) ? '0 : 16'($random(seed));
            open_compare = 16'($random(seed));
            short_compare = 16'($random(seed));
            for (int c = 0; c < CHANNELS; c++)
                grayscale_value[c*GS_BITS +: GS_BITS] = on_mask[c] ? 12'hfff : 12'h000;
            frame(40);
            `CHK(leakage_fault_flag, invisible_detect_enable ? 16'h0000 : ({16{leakage_detect_enable}} & ~on_mask & ~short_compare))
            `CHK(detect_current_level, detect_current_select)
            on_mask = invisible_detect_enable ? '1 : on_mask;
            `CHK(open_fault_flag, open_compare & on_mask)
            `CHK(short_fault_flag, short_compare & on_mask)
        end
        `CHK(seen_detect, 1'b1)
        second_gs_all_zero = 1'b1;
        for (int f = 0; f < 4; f++) begin
            power_save_field = 2'(f);
            pulse_lat();
            `CHK(power_save_state, 1'(f == 1 || f == 2))
            run = 1'b1;
            tick(64);
            run = 1'b0;
            power_save_field = 2'h1;
            sclk_req = 1'b1;
            tick(1);
            sclk_req = 1'b0;
            tick(20);
            `CHK(power_save_state, 1'b0)
            second_gs_all_zero = 1'b0;
            frame(4);
            second_gs_all_zero = 1'b1;
            `CHK(power_save_state, 1'b0)
        end
        second_gs_all_zero = 1'b0;
        grayscale_value = '1;
        shutdown_compare = 1'b1;
        tick(10);
        `CHK(thermal_error_flag, 1'b1)
        pulse_lat();
        `CHK(thermal_error_flag, 1'b1)
        shutdown_compare = 1'b0;
        warning_compare = 1'b1;
        tick(10);
        `CHK(thermal_error_flag, 1'b1)
        pulse_lat();
        `CHK(thermal_error_flag, 1'b0)
        run = 1'b1;
        tick(64);
        `CHK(sink_output_channel, 16'hffff)
        `CHK(thermal_warning_flag, 1'b1)
        warning_compare = 1'b0;
        tick(10);
        `CHK(thermal_warning_flag, 1'b1)
        pulse_lat();
        `CHK(thermal_warning_flag, 1'b0)
        reference_short_compare = 1'b1;
        tick(10);
        `CHK(reference_short_flag, 1'b1)
        `CHK(sink_output_channel, 16'h0000)
        print_verdict();
    end
endmodule : tb_lfp_core
